// ### inc/ccd_pkg.sv
// Register map, field layout and reset values for the clock output and converter clock block
package ccd_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_SRC_CFG_ADDR  = 8'h46;
  localparam logic [7:0] OUT_DIV_CFG_ADDR  = 8'h47;
  localparam logic [7:0] CONV_CFG_ADDR     = 8'h49;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_SRC_CFG_RST   = 8'h00;
  localparam logic [7:0] OUT_DIV_CFG_RST   = 8'h01;
  localparam logic [7:0] CONV_CFG_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OUT_SRC_SEL_LSB           = 0;
  localparam int OUT_SRC_SEL_MSB           = 2;
  localparam int OUT_DIV_EN_BIT            = 7;
  localparam int OUT_DIV_VAL_LSB           = 0;
  localparam int OUT_DIV_VAL_MSB           = 6;
  localparam int CONV_FREQ_LSB             = 6;
  localparam int CONV_FREQ_MSB             = 7;
  localparam int CONV_SRC_AUTO_DIS_BIT     = 5;
  localparam int CONV_SRC_MANUAL_BIT       = 4;
  localparam int CONV_EN_AUTO_DIS_BIT      = 3;
  localparam int CONV_MANUAL_EN_BIT        = 2;
  localparam int CONV_DIV_LSB              = 0;
  localparam int CONV_DIV_MSB              = 1;
  // ----------------------------------------------------------------
  // Encodings and ratios
  // ----------------------------------------------------------------
  localparam int          RATIO_W          = 8;
  localparam logic [7:0]  OUT_DIV_ZERO_RATIO = 8'h80;
  localparam logic [6:0]  OUT_DIV_ZERO_CODE  = 7'h00;
  localparam logic [2:0]  SRC_PLL          = 3'h0;
  localparam logic [2:0]  SRC_SERIAL_PRI   = 3'h1;
  localparam logic [2:0]  SRC_SERIAL_SEC   = 3'h2;
  localparam logic [2:0]  SRC_CONTROL      = 3'h3;
  localparam logic [2:0]  SRC_OSC          = 3'h4;
  localparam logic [2:0]  SRC_DSP          = 3'h5;
  // Auto-mode divide exponent per frequency code, base source taken as the 12 MHz rate
  localparam logic [1:0]  FREQ_6M_EXP      = 2'h1;
  localparam logic [1:0]  FREQ_3M_EXP      = 2'h2;
  localparam logic [1:0]  FREQ_1M5_EXP     = 2'h3;
  localparam logic [1:0]  FREQ_12M_EXP     = 2'h0;
endpackage : ccd_pkg

// ### verilog/ccd_divider.sv
// Glitch-free half-period counting divider of a sampled source clock
`timescale 1ns/1ps
`default_nettype none
module ccd_divider #(
  parameter int RATIO_W = 8
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               src_level_in,
  input  wire logic               enable_in,
  input  wire logic [RATIO_W-1:0] ratio_in,
  output logic                    clk_out
);
  // Refused at elaboration: a one-bit ratio cannot hold divide by two
  if (RATIO_W < 2) begin : g_bad_ratio_w
    $error("ccd_divider: RATIO_W too small");
  end

  logic               src_d_ff, nxt_src_d;
  logic               run_ff,   nxt_run;
  logic               out_ff,   nxt_out;
  logic [RATIO_W-1:0] cnt_ff,   nxt_cnt;
  logic [RATIO_W-1:0] ratio_ff, nxt_ratio;
  logic               edge_seen;
  logic               terminal;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Output toggles every ratio source edges, so odd ratios divide exactly
  always_comb begin
    edge_seen = src_level_in ^ src_d_ff;
    terminal  = edge_seen && (cnt_ff == ratio_ff - RATIO_W'(1));
    nxt_src_d = src_level_in;
    nxt_run   = run_ff;
    nxt_out   = out_ff;
    nxt_cnt   = cnt_ff;
    nxt_ratio = ratio_ff;
    if (!run_ff) begin
      if (enable_in) begin
        nxt_run   = 1'b1;
        nxt_cnt   = '0;
        nxt_ratio = ratio_in;
      end
    end else if (terminal) begin
      // Ratio picked up only on a phase boundary, so no runt phase
      nxt_cnt   = '0;
      nxt_ratio = ratio_in;
      if (!enable_in && !out_ff) begin
        nxt_run = 1'b0;
      end else begin
        nxt_out = ~out_ff;
      end
    end else if (edge_seen) begin
      nxt_cnt = cnt_ff + RATIO_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_d_ff <= 1'b0;
      run_ff   <= 1'b0;
      out_ff   <= 1'b0;
      cnt_ff   <= '0;
      ratio_ff <= RATIO_W'(1);
    end else begin
      src_d_ff <= nxt_src_d;
      run_ff   <= nxt_run;
      out_ff   <= nxt_out;
      cnt_ff   <= nxt_cnt;
      ratio_ff <= nxt_ratio;
    end
  end

  assign clk_out = out_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  idle_static_a: assert property (!run_ff |=> $stable(out_ff))
    else $error("divider output moved while stopped");
  toggle_boundary_a: assert property ($changed(out_ff) |-> $past(terminal))
    else $error("divider output toggled off a phase boundary");
  ratio_hold_a: assert property (run_ff && !terminal |=> $stable(ratio_ff))
    else $error("ratio changed mid phase");
  stop_low_a: assert property (!run_ff |-> !out_ff)
    else $error("divider stopped with output high");
endmodule : ccd_divider
`default_nettype wire

// ### verilog/ccd_clock_ctrl.sv
// Clock output divider and converter clock divider with their control registers
`timescale 1ns/1ps
`default_nettype none
module ccd_clock_ctrl (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       reg_wr_en_in,
  input  wire logic       reg_rd_en_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       pll_clk_in,
  input  wire logic       serial_bclk_pri_in,
  input  wire logic       serial_bclk_sec_in,
  input  wire logic       control_clock_in,
  input  wire logic       osc_clk_in,
  input  wire logic       dsp_clk_in,
  input  wire logic       audio_clk_in,
  input  wire logic       audio_clk_detected_in,
  input  wire logic       conv_request_in,
  output logic [7:0]      reg_rdata_out,
  output logic            general_clock_output_out,
  output logic            conv_clock_out,
  output logic            conv_source_is_osc_out,
  output logic            conv_divider_on_out
);
  localparam int RW = ccd_pkg::RATIO_W;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [RW-1:0] pow2_ratio(input logic [1:0] exp_code);
    pow2_ratio = RW'(1) << exp_code;
  endfunction : pow2_ratio

  function automatic logic [1:0] freq_exp(input logic [1:0] code);
    unique case (code)
      2'h0: freq_exp = ccd_pkg::FREQ_6M_EXP;
      2'h1: freq_exp = ccd_pkg::FREQ_3M_EXP;
      2'h2: freq_exp = ccd_pkg::FREQ_1M5_EXP;
      2'h3: freq_exp = ccd_pkg::FREQ_12M_EXP;
    endcase
  endfunction : freq_exp

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] out_src_cfg_ff, nxt_out_src_cfg;
  logic [7:0] out_div_cfg_ff, nxt_out_div_cfg;
  logic [7:0] conv_cfg_ff,    nxt_conv_cfg;
  logic [7:0] rdata_ff,       nxt_rdata;
  logic       src_osc_ff,     nxt_src_osc;
  logic       conv_on_ff,     nxt_conv_on;

  always_comb begin
    nxt_out_src_cfg = out_src_cfg_ff;
    nxt_out_div_cfg = out_div_cfg_ff;
    nxt_conv_cfg    = conv_cfg_ff;
    nxt_rdata       = rdata_ff;
    if (reg_wr_en_in) begin
      unique case (reg_addr_in)
        ccd_pkg::OUT_SRC_CFG_ADDR: nxt_out_src_cfg = {5'h00, reg_wdata_in[2:0]};
        ccd_pkg::OUT_DIV_CFG_ADDR: nxt_out_div_cfg = reg_wdata_in;
        ccd_pkg::CONV_CFG_ADDR:    nxt_conv_cfg    = reg_wdata_in;
        default:                   nxt_conv_cfg    = conv_cfg_ff;
      endcase
    end
    if (reg_rd_en_in) begin
      unique case (reg_addr_in)
        ccd_pkg::OUT_SRC_CFG_ADDR: nxt_rdata = out_src_cfg_ff;
        ccd_pkg::OUT_DIV_CFG_ADDR: nxt_rdata = out_div_cfg_ff;
        ccd_pkg::CONV_CFG_ADDR:    nxt_rdata = conv_cfg_ff;
        default:                   nxt_rdata = ccd_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_src_cfg_ff <= ccd_pkg::OUT_SRC_CFG_RST;
      out_div_cfg_ff <= ccd_pkg::OUT_DIV_CFG_RST;
      conv_cfg_ff    <= ccd_pkg::CONV_CFG_RST;
      rdata_ff       <= ccd_pkg::UNMAPPED_READ;
    end else begin
      out_src_cfg_ff <= nxt_out_src_cfg;
      out_div_cfg_ff <= nxt_out_div_cfg;
      conv_cfg_ff    <= nxt_conv_cfg;
      rdata_ff       <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Clock output divider control
  // ----------------------------------------------------------------
  logic [2:0]    clock_out_source_select;
  logic          clock_out_divider_enable;
  logic [6:0]    clock_out_divide_value;
  logic [RW-1:0] out_ratio;
  logic          out_src_level;

  always_comb begin
    clock_out_source_select  = out_src_cfg_ff[ccd_pkg::OUT_SRC_SEL_MSB:ccd_pkg::OUT_SRC_SEL_LSB];
    clock_out_divider_enable = out_div_cfg_ff[ccd_pkg::OUT_DIV_EN_BIT];
    clock_out_divide_value   = out_div_cfg_ff[ccd_pkg::OUT_DIV_VAL_MSB:ccd_pkg::OUT_DIV_VAL_LSB];
    if (clock_out_divide_value == ccd_pkg::OUT_DIV_ZERO_CODE) begin
      out_ratio = ccd_pkg::OUT_DIV_ZERO_RATIO;
    end else begin
      out_ratio = {1'b0, clock_out_divide_value};
    end
    // Reserved codes give a dead source, so the output stays static
    unique case (clock_out_source_select)
      ccd_pkg::SRC_PLL:        out_src_level = pll_clk_in;
      ccd_pkg::SRC_SERIAL_PRI: out_src_level = serial_bclk_pri_in;
      ccd_pkg::SRC_SERIAL_SEC: out_src_level = serial_bclk_sec_in;
      ccd_pkg::SRC_CONTROL:    out_src_level = control_clock_in;
      ccd_pkg::SRC_OSC:        out_src_level = osc_clk_in;
      ccd_pkg::SRC_DSP:        out_src_level = dsp_clk_in;
      default:                 out_src_level = 1'b0;
    endcase
  end

  ccd_divider #(.RATIO_W(RW)) u_out_div (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .src_level_in(out_src_level),
    .enable_in   (clock_out_divider_enable),
    .ratio_in    (out_ratio),
    .clk_out     (general_clock_output_out)
  );

  // ----------------------------------------------------------------
  // Converter clock control
  // ----------------------------------------------------------------
  logic [1:0]    conv_clock_freq_select;
  logic          conv_source_auto_disable;
  logic          conv_source_manual_select;
  logic          conv_enable_auto_disable;
  logic          conv_manual_enable;
  logic [1:0]    conv_manual_divide;
  logic [RW-1:0] conv_ratio;
  logic          conv_src_level;

  always_comb begin
    conv_clock_freq_select    = conv_cfg_ff[ccd_pkg::CONV_FREQ_MSB:ccd_pkg::CONV_FREQ_LSB];
    conv_source_auto_disable  = conv_cfg_ff[ccd_pkg::CONV_SRC_AUTO_DIS_BIT];
    conv_source_manual_select = conv_cfg_ff[ccd_pkg::CONV_SRC_MANUAL_BIT];
    conv_enable_auto_disable  = conv_cfg_ff[ccd_pkg::CONV_EN_AUTO_DIS_BIT];
    conv_manual_enable        = conv_cfg_ff[ccd_pkg::CONV_MANUAL_EN_BIT];
    conv_manual_divide        = conv_cfg_ff[ccd_pkg::CONV_DIV_MSB:ccd_pkg::CONV_DIV_LSB];
    // Auto source falls back to the oscillator when no audio clock is seen
    if (conv_source_auto_disable) begin
      nxt_src_osc = conv_source_manual_select;
    end else begin
      nxt_src_osc = !audio_clk_detected_in;
    end
    if (conv_enable_auto_disable) begin
      nxt_conv_on = conv_manual_enable;
    end else begin
      nxt_conv_on = conv_request_in;
    end
    if (conv_enable_auto_disable) begin
      conv_ratio = pow2_ratio(conv_manual_divide);
    end else begin
      conv_ratio = pow2_ratio(freq_exp(conv_clock_freq_select));
    end
    conv_src_level = src_osc_ff ? osc_clk_in : audio_clk_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_osc_ff <= 1'b0;
      conv_on_ff <= 1'b0;
    end else begin
      src_osc_ff <= nxt_src_osc;
      conv_on_ff <= nxt_conv_on;
    end
  end

  // Source swap reaches the divider only as edges, ratio latched per phase
  ccd_divider #(.RATIO_W(RW)) u_conv_div (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .src_level_in(conv_src_level),
    .enable_in   (conv_on_ff),
    .ratio_in    (conv_ratio),
    .clk_out     (conv_clock_out)
  );

  assign reg_rdata_out          = rdata_ff;
  assign conv_source_is_osc_out = src_osc_ff;
  assign conv_divider_on_out    = conv_on_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  div_reset_a: assert property ($fell(rst_in) |-> out_div_cfg_ff == 8'h01)
    else $error("output divider register reset value wrong");
  conv_reset_a: assert property ($fell(rst_in) |-> conv_cfg_ff == 8'h00)
    else $error("converter register reset value wrong");
  div_enable_a: assert property (clock_out_divider_enable == out_div_cfg_ff[7])
    else $error("output divider enable not bit 7");
  div_code_a: assert property (out_ratio == ((out_div_cfg_ff[6:0] == 7'h00) ? 8'h80
                                             : {1'b0, out_div_cfg_ff[6:0]}))
    else $error("output divide code mapped wrong");
  freq_map_a: assert property (!conv_cfg_ff[3] |-> conv_ratio == ((conv_cfg_ff[7:6] == 2'h3) ? 8'h01
                              : (8'h02 << conv_cfg_ff[7:6])))
    else $error("frequency code ratio wrong");
  src_auto_a: assert property (!conv_cfg_ff[5] |=> src_osc_ff == !$past(audio_clk_detected_in))
    else $error("auto source choice wrong");
  src_manual_a: assert property (conv_cfg_ff[5] |=> src_osc_ff == $past(conv_cfg_ff[4]))
    else $error("manual source choice wrong");
  en_auto_a: assert property (!conv_cfg_ff[3] |=> conv_on_ff == $past(conv_request_in))
    else $error("auto enable not followed");
  en_manual_a: assert property (conv_cfg_ff[3] |=> conv_on_ff == $past(conv_cfg_ff[2]))
    else $error("manual enable not followed");
  div_manual_a: assert property (conv_cfg_ff[3] |-> conv_ratio == (8'h01 << conv_cfg_ff[1:0]))
    else $error("manual converter ratio wrong");
  sel_reserved_a: assert property (clock_out_source_select[2:1] == 2'b11 |-> !out_src_level)
    else $error("reserved source not static");
  rd_unmapped_a: assert property (reg_rd_en_in && reg_addr_in == 8'h48 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");

  out_runs_c: cover property (clock_out_divider_enable ##1 $rose(general_clock_output_out));
  conv_runs_c: cover property (conv_on_ff ##1 $rose(conv_clock_out));
  src_swap_c: cover property ($changed(src_osc_ff) && conv_on_ff);
  div128_c: cover property (clock_out_divider_enable && out_ratio == 8'h80);
endmodule : ccd_clock_ctrl
`default_nettype wire

// ### tb/ccd_clock_ctrl_tb.sv
// Self-checking bench for the clock output and converter clock block
`timescale 1ns/1ps
`default_nettype none
module clock_out_and_sar_clock_divider_test;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       wr_en  = 1'b0;
  logic       rd_en  = 1'b0;
  logic [7:0] addr   = 8'h00;
  logic [7:0] wdata  = 8'h00;
  logic [6:0] src    = 7'h00;
  logic       det    = 1'b0;
  logic       req    = 1'b0;
  logic [7:0] rdata;
  logic       gen_clk;
  logic       conv_clk;
  logic       is_osc;
  logic       div_on;
  // Half periods in clk cycles: pll, bclk1, bclk2, control, osc, dsp, audio
  int         half [7] = '{6, 3, 4, 5, 2, 7, 3};
  int         cnt [7];
  int         regm [int];
  int         miscompares = 0;
  int         checks_done = 0;
  always #4 clk_in = ~clk_in;
  ccd_clock_ctrl u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .pll_clk_in(src[0]),
    .serial_bclk_pri_in(src[1]), .serial_bclk_sec_in(src[2]), .control_clock_in(src[3]),
    .osc_clk_in(src[4]), .dsp_clk_in(src[5]), .audio_clk_in(src[6]),
    .audio_clk_detected_in(det), .conv_request_in(req), .reg_rdata_out(rdata),
    .general_clock_output_out(gen_clk), .conv_clock_out(conv_clk),
    .conv_source_is_osc_out(is_osc), .conv_divider_on_out(div_on));
  // Sources change on the falling edge so every level spans whole cycles
  always @(negedge clk_in) begin
    for (int i = 0; i < 7; i++) begin
      if (cnt[i] + 1 >= half[i]) begin
        cnt[i] <= 0;
        src[i] <= ~src[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t flag got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t count got %h exp %h", $time, got, exp);
    end
  endtask : chk_cnt
  function automatic logic pick(input int sel);
    return (sel != 0) ? conv_clk : gen_clk;
  endfunction : pick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk_in);
    wr_en = 1'b0;
    if (regm.exists(a)) regm[a] = (a == ccd_pkg::OUT_SRC_CFG_ADDR) ? (d & 8'h07) : d;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a);
    @(negedge clk_in);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk_in);
    rd_en = 1'b0;
    chk_reg(rdata, regm.exists(a) ? 8'(regm[a]) : 8'h00);
  endtask : rd_chk
  // Skips the first edge so a ratio change in flight has settled
  task automatic measure(input int sel, input int exp);
    int   n;
    int   edges;
    int   t2;
    logic prev;
    n = 0;
    edges = 0;
    t2 = 0;
    prev = pick(sel);
    while (edges < 3) begin
      @(negedge clk_in);
      n++;
      if (pick(sel) === 1'b1 && prev === 1'b0) edges++;
      if (edges == 2 && t2 == 0) t2 = n;
      prev = pick(sel);
      if (n > 5000) begin
        miscompares++;
        $display("Timeout waiting for a clock edge");
        final_report();
      end
    end
    chk_cnt(n - t2, exp);
  endtask : measure
  task automatic stay(input int sel);
    logic first;
    int   moves;
    // A disabled divider finishes its running phase before it goes static; a dead source freezes it mid phase
    repeat (60) @(negedge clk_in);
    first = pick(sel);
    moves = 0;
    repeat (200) begin
      @(negedge clk_in);
      if (pick(sel) !== first) moves++;
    end
    chk_cnt(moves, 0);
  endtask : stay
  // Shortest whole phase while a new ratio lands at cycle k
  task automatic glitch_probe(input int k, input logic [7:0] d, output int shortest);
    int   n;
    int   run;
    logic prev;
    logic seen;
    n = 0;
    run = 0;
    seen = 1'b0;
    shortest = 9999;
    prev = gen_clk;
    addr = ccd_pkg::OUT_DIV_CFG_ADDR;
    wdata = d;
    repeat (300) begin
      @(negedge clk_in);
      n++;
      run++;
      wr_en = (n == k);
      if (gen_clk !== prev) begin
        if (seen && run < shortest) shortest = run;
        seen = 1'b1;
        run = 0;
      end
      prev = gen_clk;
    end
    regm[ccd_pkg::OUT_DIV_CFG_ADDR] = d;
  endtask : glitch_probe
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int         sh;
    int         fr [4];
    int         codes [$];
    logic [7:0] d;
    fr = '{2, 4, 8, 1};
    d = 8'($urandom(67));
    regm[ccd_pkg::OUT_SRC_CFG_ADDR] = 8'h00;
    regm[ccd_pkg::OUT_DIV_CFG_ADDR] = 8'h01;
    regm[ccd_pkg::CONV_CFG_ADDR] = 8'h00;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    rd_chk(8'h47);
    rd_chk(8'h49);
    rd_chk(8'h46);
    rd_chk(8'h48);
    chk_bit(gen_clk, 1'b0);
    $display("Test reset values done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(8'h46, d);
      wr(8'h47, d ^ 8'h5a);
      wr(8'h49, ~d);
      wr(8'h48, d);
      for (int a = 8'h46; a <= 8'h49; a++) rd_chk(8'(a));
    end
    $display("Test register access done");
    wr(8'h47, 8'h81);
    for (int c = 0; c < 8; c++) begin
      wr(8'h46, 8'(c));
      if (c < 6) measure(0, 2 * half[c]);
      else stay(0);
    end
    $display("Test source select done");
    wr(8'h46, 8'h04);
    codes = '{1, 2, 3, 127, 0};
    codes.push_back(4 + $urandom % 123);
    codes.push_back(4 + $urandom % 123);
    foreach (codes[i]) begin
      wr(8'h47, 8'h80 | 8'(codes[i]));
      measure(0, ((codes[i] == 0) ? 128 : codes[i]) * 4);
    end
    $display("Test divide values done");
    wr(8'h47, 8'h05);
    // Old ratio may be up to 126, so one phase can last 252 cycles
    repeat (600) @(negedge clk_in);
    chk_bit(gen_clk, 1'b0);
    stay(0);
    wr(8'h47, 8'h85);
    measure(0, 20);
    $display("Test enable done");
    wr(8'h47, 8'h88);
    glitch_probe(20 + $urandom % 16, 8'h82, sh);
    chk_cnt(int'(sh >= 4), 1);
    measure(0, 8);
    $display("Test ratio change done");
    req = 1'b1;
    for (int f = 0; f < 4; f++) begin
      wr(8'h49, 8'(f << 6) | 8'h17);
      measure(1, fr[f] * 4);
      chk_bit(is_osc, 1'b1);
      chk_bit(div_on, 1'b1);
    end
    wr(8'h49, 8'h00);
    det = 1'b1;
    repeat (4) @(negedge clk_in);
    chk_bit(is_osc, 1'b0);
    measure(1, 12);
    req = 1'b0;
    repeat (4) @(negedge clk_in);
    chk_bit(div_on, 1'b0);
    $display("Test converter auto done");
    for (int v = 0; v < 4; v++) begin
      wr(8'h49, 8'h3c | 8'(v));
      measure(1, (1 << v) * 4);
      chk_bit(is_osc, 1'b1);
      chk_bit(div_on, 1'b1);
    end
    wr(8'h49, 8'h28);
    repeat (4) @(negedge clk_in);
    chk_bit(div_on, 1'b0);
    chk_bit(is_osc, 1'b0);
    stay(1);
    wr(8'h49, 8'h2d);
    measure(1, 12);
    $display("Test converter manual done");
    final_report();
  end
endmodule : clock_out_and_sar_clock_divider_test
`default_nettype wire
